// ---- logic/cmp_ctrl_pkg.sv ----
// Package: register map, field positions and reset values of the comparator control block
`default_nettype none
package cmp_ctrl_pkg;
  localparam logic [7:0] CONTROL_ADDR = 8'h00;
  localparam int ENABLE_BIT = 15;
  localparam int PIN_DRIVE_BIT = 14;
  localparam int INVERT_BIT = 13;
  localparam int STATUS_BIT = 8;
  localparam int EDGE_LO = 6;
  localparam int POS_SEL_BIT = 4;
  localparam int NEG_LO = 0;
  localparam logic [1:0] EDGE_RESET = 2'h3;
  localparam logic [1:0] NEG_RESET = 2'h3;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] NEG_OWN_PIN = 2'h0;
  localparam logic [1:0] NEG_FIRST_POS = 2'h1;
  localparam logic [1:0] NEG_SECOND_POS = 2'h2;
  localparam logic [1:0] NEG_BAND_REF = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- logic/cmp_result_sync.sv ----
// Two-stage synchroniser for the asynchronous comparator result
`default_nettype none
module cmp_result_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// ---- logic/cmp_edge_detect.sv ----
// Edge detector producing one-cycle event pulses on a selected edge
`default_nettype none
module cmp_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level,
  input wire logic [1:0] edge_select,
  output logic event_pulse
);
  typedef struct packed {
    logic prev;
    logic pulse;
  } edge_state_t;
  edge_state_t s_q;
  edge_state_t s_d;

  // Compare with last sample; pulse registered so the output is clean
  always_comb begin
    s_d.prev = level;
    unique case (edge_select)
      cmp_ctrl_pkg::EDGE_OFF: s_d.pulse = 1'b0;
      cmp_ctrl_pkg::EDGE_RISE: s_d.pulse = level & ~s_q.prev;
      cmp_ctrl_pkg::EDGE_FALL: s_d.pulse = ~level & s_q.prev;
      cmp_ctrl_pkg::EDGE_BOTH: s_d.pulse = level ^ s_q.prev;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_pulse = s_q.pulse;
endmodule
`default_nettype wire

// ---- logic/comparator_control_logic.sv ----
// Comparator control register, input routing, result path and event logic
`default_nettype none
module comparator_control_logic (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog core
  input wire logic comparator_raw,
  output logic comparator_enable,
  output logic positive_input_select,
  output logic [1:0] negative_input_select,
  // Pin and event
  output logic comparator_output_pin_o,
  output logic comparator_output_pin_oe_n,
  output logic comparator_event
);
  typedef struct packed {
    logic enable;
    logic pin_drive;
    logic invert;
    logic [1:0] edge_sel;
    logic pos_sel;
    logic [1:0] neg_sel;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic pin_val;
    logic pin_oe_n;
  } ctrl_state_t;
  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic result_sync;
  logic result_adj;
  logic take;
  logic read_take;
  logic write_take;

  ////////////////////////////////////////////////////////////////////
  // Layout constants; the logic below assumes these shapes
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int FIELD2_W = 2;
  localparam int DECODE_W = 8;
  localparam int USED_BITS = 9;
  localparam int ALIGN_W = 2;

  // Single-bit mask at a field position
  function automatic logic [31:0] bit_at(input int pos);
    logic [31:0] m;
    m = cmp_ctrl_pkg::ZERO_WORD;
    m[pos] = 1'b1;
    return m;
  endfunction

  // Every implemented position, status included; the rest reads zero
  function automatic logic [31:0] used_mask();
    logic [31:0] m;
    m = bit_at(cmp_ctrl_pkg::ENABLE_BIT);
    m = m | bit_at(cmp_ctrl_pkg::PIN_DRIVE_BIT);
    m = m | bit_at(cmp_ctrl_pkg::INVERT_BIT);
    m = m | bit_at(cmp_ctrl_pkg::STATUS_BIT);
    m = m | bit_at(cmp_ctrl_pkg::EDGE_LO);
    m = m | bit_at(cmp_ctrl_pkg::EDGE_LO + FIELD2_W - 1);
    m = m | bit_at(cmp_ctrl_pkg::POS_SEL_BIT);
    m = m | bit_at(cmp_ctrl_pkg::NEG_LO);
    m = m | bit_at(cmp_ctrl_pkg::NEG_LO + FIELD2_W - 1);
    return m;
  endfunction

  // Readback mask, so a stray field can never leak into a hole
  localparam logic [31:0] USED_MASK = used_mask();

  ////////////////////////////////////////////////////////////////////
  // Elaboration checks: a layout edit the logic cannot serve stops the build
  if (cmp_ctrl_pkg::ENABLE_BIT >= HALF_W) begin : g_enable_pos
    $error("enable bit must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::PIN_DRIVE_BIT >= HALF_W) begin : g_drive_pos
    $error("pin drive bit must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::INVERT_BIT >= HALF_W) begin : g_invert_pos
    $error("invert bit must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::STATUS_BIT >= HALF_W) begin : g_status_pos
    $error("status bit must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::POS_SEL_BIT >= HALF_W) begin : g_pos_sel_pos
    $error("positive select bit must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::EDGE_LO + FIELD2_W > HALF_W) begin : g_edge_pos
    $error("edge field must sit in the low half-word");
  end

  if (cmp_ctrl_pkg::NEG_LO + FIELD2_W > HALF_W) begin : g_neg_pos
    $error("negative select field must sit in the low half-word");
  end

  // Two fields sharing a bit would make readback ambiguous
  if ($countones(USED_MASK) != USED_BITS) begin : g_overlap
    $error("control fields overlap");
  end

  if (USED_MASK[WORD_W-1:HALF_W] != '0) begin : g_upper_half
    $error("upper half-word must stay unimplemented");
  end

  if (cmp_ctrl_pkg::CONTROL_ADDR[ALIGN_W-1:0] != '0) begin : g_align
    $error("control register must be word aligned");
  end

  if ($bits(cmp_ctrl_pkg::CONTROL_ADDR) != DECODE_W) begin : g_decode_w
    $error("decode width must match the register address");
  end

  if ($bits(cmp_ctrl_pkg::EDGE_RESET) != FIELD2_W) begin : g_edge_reset_w
    $error("edge reset value must match the field width");
  end

  if ($bits(cmp_ctrl_pkg::NEG_RESET) != FIELD2_W) begin : g_neg_reset_w
    $error("negative select reset must match the field width");
  end

  if ($bits(cmp_ctrl_pkg::ZERO_WORD) != WORD_W) begin : g_word_w
    $error("zero word must match the bus width");
  end

  // Duplicate codes would break the unique case in the edge detector
  if (cmp_ctrl_pkg::EDGE_RISE == cmp_ctrl_pkg::EDGE_FALL ||
      cmp_ctrl_pkg::EDGE_OFF == cmp_ctrl_pkg::EDGE_BOTH) begin : g_edge_codes
    $error("edge select codes must be distinct");
  end

  // Transfer decode looks only at the upper transfer bit
  if (!cmp_ctrl_pkg::HTRANS_NONSEQ[1]) begin : g_nonseq
    $error("a non-sequential transfer must set the upper transfer bit");
  end

  ////////////////////////////////////////////////////////////////////
  // Helpers shared by the datapath
  // Address decode, shared by the read and the write path
  function automatic logic hits_control(input logic [DECODE_W-1:0] a);
    return a == cmp_ctrl_pkg::CONTROL_ADDR;
  endfunction

  // Disabled core reads low before inversion, which precedes status and edges
  function automatic logic adjust(input logic raw, input logic en, input logic inv);
    return (raw & en) ^ inv;
  endfunction

  // Two-bit field at a given low position
  function automatic logic [1:0] field2(input logic [31:0] w, input int lo);
    return w[lo +: FIELD2_W];
  endfunction

  // One written word; status and holes are never stored
  function automatic ctrl_state_t write_fields(input ctrl_state_t s, input logic [31:0] w);
    ctrl_state_t n;
    n = s;
    n.enable = w[cmp_ctrl_pkg::ENABLE_BIT];
    n.pin_drive = w[cmp_ctrl_pkg::PIN_DRIVE_BIT];
    n.invert = w[cmp_ctrl_pkg::INVERT_BIT];
    n.edge_sel = field2(w, cmp_ctrl_pkg::EDGE_LO);
    n.pos_sel = w[cmp_ctrl_pkg::POS_SEL_BIT];
    n.neg_sel = field2(w, cmp_ctrl_pkg::NEG_LO);
    return n;
  endfunction

  // Pin value: result only while the pin is driven
  function automatic logic pin_next(input logic res, input logic drive);
    return res & drive;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Result path
  cmp_result_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(comparator_raw),
    .sync_out(result_sync)
  );

  // Off comparator reads low before inversion, which precedes status and edges
  assign result_adj = adjust(result_sync, s_q.enable, s_q.invert);

  cmp_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(result_adj),
    .edge_select(s_q.edge_sel),
    .event_pulse(comparator_event)
  );

  // Readback word; status bit live, unimplemented bits zero
  function automatic logic [31:0] read_word(input ctrl_state_t s, input logic res);
    logic [31:0] w;
    w = cmp_ctrl_pkg::ZERO_WORD;
    w[cmp_ctrl_pkg::ENABLE_BIT] = s.enable;
    w[cmp_ctrl_pkg::PIN_DRIVE_BIT] = s.pin_drive;
    w[cmp_ctrl_pkg::INVERT_BIT] = s.invert;
    w[cmp_ctrl_pkg::STATUS_BIT] = res;
    w[cmp_ctrl_pkg::EDGE_LO +: 2] = s.edge_sel;
    w[cmp_ctrl_pkg::POS_SEL_BIT] = s.pos_sel;
    w[cmp_ctrl_pkg::NEG_LO +: 2] = s.neg_sel;
    return w & USED_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  // Sequential transfers would be taken the same way as non-sequential
  assign take = hsel & hready & htrans[1];
  assign read_take = take & ~hwrite;
  assign write_take = take & hwrite;

  // Next state: bus phases, register fields, then the pin
  always_comb begin
    s_d = s_q;
    // Write address phase is remembered until its data phase
    s_d.wr_pend = write_take;
    s_d.wr_addr = haddr[DECODE_W-1:0];
    // Read data registered here; they stand for the whole data phase
    if (read_take) begin
      if (hits_control(haddr[DECODE_W-1:0])) begin
        s_d.rdata = read_word(s_q, result_adj);
      end else begin
        // Unmapped words read zero
        s_d.rdata = cmp_ctrl_pkg::ZERO_WORD;
      end
    end
    // Whole word written at once; every field, enable included, loads from hwdata
    if (s_q.wr_pend && hits_control(s_q.wr_addr)) begin
      s_d = write_fields(s_d, hwdata);
    end
    // Pin registered; enable low drives
    s_d.pin_val = pin_next(result_adj, s_q.pin_drive);
    s_d.pin_oe_n = ~s_q.pin_drive;
  end

  // Reset: fields at their reset values, pin released
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.edge_sel <= cmp_ctrl_pkg::EDGE_RESET;
      s_q.neg_sel <= cmp_ctrl_pkg::NEG_RESET;
      s_q.pin_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs to bus: never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Read data straight from the flop
  assign hrdata = s_q.rdata;
  // Analog core controls; fields survive an enable change
  assign comparator_enable = s_q.enable;
  assign positive_input_select = s_q.pos_sel;
  assign negative_input_select = s_q.neg_sel;
  // Pin pair, both registered so they switch together
  assign comparator_output_pin_o = s_q.pin_val;
  assign comparator_output_pin_oe_n = s_q.pin_oe_n;
endmodule
`default_nettype wire

// ---- dv/cmp_core_model.sv ----
// Behavioural comparator core with its input pins and references
`default_nettype none
module cmp_core_model (
  input wire logic comparator_enable,
  input wire logic positive_input_select,
  input wire logic [1:0] negative_input_select,
  input wire logic [31:0] v,
  output logic comparator_raw
);
  logic [1:0] ns;
  logic [7:0] n;
  // Bytes: own plus, own minus, second plus, reference; an unpowered core gives garbage
  assign ns = negative_input_select;
  assign n = ns == 2'h0 ? v[15:8] : ns == 2'h1 ? v[7:0] : v[8*ns+:8];
  assign comparator_raw = !comparator_enable ? ^v :
    (positive_input_select ? v[31:24] : v[7:0]) > n;
endmodule
`default_nettype wire

// ---- dv/cmp_checker.sv ----
// Port checks of the comparator control block
`default_nettype none
module cmp_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic comparator_enable,
  input wire logic positive_input_select,
  input wire logic [1:0] negative_input_select,
  input wire logic comparator_output_pin_o,
  input wire logic comparator_output_pin_oe_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted address phase
  sequence acc_s; hsel && hready && htrans[1]; endsequence
  ready_okay_a: assert property (hreadyout && !hresp) else $error("stall");
  zero_bits_a: assert property (!(hrdata & 32'hFFFF_1E2C)) else $error("dead bit");
  hole_zero_a: assert property (acc_s ##0 !hwrite && haddr == 32'h4 |=> !hrdata)
    else $error("hole");
  enable_track_a: assert property (acc_s ##0 hwrite && !haddr |-> ##2
    comparator_enable == $past(hwdata[15])) else $error("enable");
  select_track_a: assert property (acc_s ##0 hwrite && !haddr |-> ##2
    {positive_input_select, negative_input_select} == $past({hwdata[4], hwdata[1:0]}))
    else $error("select");
  drive_track_a: assert property (acc_s ##0 hwrite && !haddr |-> ##3
    comparator_output_pin_oe_n == !$past(hwdata[14], 2)) else $error("drive");
  pin_quiet_a: assert property (comparator_output_pin_oe_n |-> !comparator_output_pin_o)
    else $error("pin");
  readback_a: assert property (acc_s ##0 !hwrite && !haddr |=>
    hrdata[15] == $past(comparator_enable)) else $error("readback");
endmodule
bind comparator_control_logic cmp_checker cmp_checker_inst (.*);
`default_nettype wire

// ---- dv/comparator_control_logic_tb.sv ----
// Random and corner tests of the comparator control block
`default_nettype none
module comparator_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, rdy, s0, s1;
  logic comparator_raw, comparator_enable, positive_input_select;
  logic comparator_output_pin_o, comparator_output_pin_oe_n, comparator_event;
  logic [1:0] htrans, negative_input_select;
  logic [31:0] haddr, hwdata, hrdata, v, x, d, rd, cnt;
  int mismatches = 0;
  int checked = 0;
  comparator_control_logic comparator_control_logic_inst (.*, .hsize(3'h2), .hready(rdy),
    .hreadyout(rdy), .hresp());
  cmp_core_model cmp_core_model_inst (.*);
  // Bus clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Hang guard, ten times the expected run
  initial begin
    #40us;
    mismatches++;
    summarize();
  end
  task automatic summarize();
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One word; each phase held until ready is seen
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  // Adjusted result: off core reads zero, then inversion
  function automatic logic st(input logic [31:0] c, input logic [31:0] y);
    logic [1:0] k;
    k = c[1:0] ^ {1'b0, ~c[1]};
    return (y[8 * (c[4] ? 3 : 0) +: 8] > y[8 * k +: 8]) & c[15] ^ c[13];
  endfunction
  // Reset value, hole, then random words and input swings
  initial begin
    {hwrite, htrans, haddr, hwdata, v} = '0;
    hsel = 1'b1;
    hresetn = 1'b0;
    void'($urandom(32'hCD95F53B));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0000_00C3);
    bus(1'b1, 32'h4, 32'hFFFF_FFFF);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      d = i == 0 ? 32'hFFFF_FFFF : i == 1 ? 32'h0 : $urandom;
      x = $urandom;
      v <= x;
      bus(1'b1, 32'h0, d);
      repeat (8) @(posedge hclk);
      s0 = st(d, x);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, d & 32'h0000_E0D3 | 32'(s0) << 8);
      chk(32'({comparator_output_pin_oe_n, comparator_output_pin_o}),
        32'({~d[14], d[14] & s0}));
      x = $urandom;
      v <= x;
      s1 = st(d, x);
      cnt = 0;
      // Sampled mid-cycle, away from the edge that launches the pulse
      repeat (10) begin
        @(negedge hclk);
        cnt += 32'(comparator_event);
      end
      chk(cnt, 32'((s0 != s1) & (s1 ? d[6] : d[7])));
    end
    // Mid-run reset brings back the reset word and a released pin
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0000_00C3);
    chk(32'({comparator_output_pin_oe_n, comparator_output_pin_o}), 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
